// file: core/display_cfg.svh
// Constants of the display instruction decoder: APB offsets, field positions and timing counts.
// Assumes a 50 MHz pclk; included by bare name wherever the constants are needed.
`ifndef DISPLAY_CFG_SVH
`define DISPLAY_CFG_SVH

`define REG_CONTROL_ADDR    12'h000
`define REG_STATUS_ADDR     12'h004
`define REG_COUNTER_ADDR    12'h008

`define CTRL_RESUME_BIT     0
`define WORD_INSTR_BIT      15
`define WORD_CONTROL_BIT    14
`define WORD_OP_HI          13
`define WORD_OP_LO          11
`define STA_HALT_BIT        10
`define STA_IRQ_EN_BIT      8
`define STA_SLANT_BIT       6
`define STA_PEN_EN_BIT      4
`define STA_SYNC_BIT        2
`define STB_LOAD_BIT        6

`define ST_HALT_BIT         0
`define ST_SYNC_BIT         1
`define ST_IRQ_EN_BIT       2
`define ST_SLANT_BIT        3
`define ST_PEN_EN_BIT       4
`define ST_HUNG_BIT         5
`define ST_RUN_BIT          6
`define ST_STEP_LO          8

`define CLK_PERIOD_NS       20
`define STATE_TIME_NS       200
`define STATE_CYCLES        ((`STATE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PEN_PULSE_NS        2000
`define PEN_PULSE_CYCLES    ((`PEN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define MODE_GRAPHIC        4'h8
`define MODE_JUMP           4'hC
`define MODE_NOOP           4'hD
`define MODE_STATUS_A       4'hE
`define MODE_STATUS_B       4'hF
`define MODE_GRAPH_X        4'h4
`define MODE_GRAPH_Y        4'h5
`define MODE_DATA_SPARE     4'h7

`endif

// file: core/display_pkg.sv
// Types shared by the display instruction decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package display_pkg;
	typedef enum logic [2:0] {
		SEQ_IDLE       = 3'b000,
		SEQ_FETCH      = 3'b001,
		SEQ_LOAD_MODE  = 3'b010,
		SEQ_LOAD_PULSE = 3'b011,
		SEQ_TP1        = 3'b100,
		SEQ_TP2        = 3'b101,
		SEQ_WAIT       = 3'b110,
		SEQ_HUNG       = 3'b111
	} seq_state_type;
endpackage

// file: core/display_instr_decode_status.sv
// Display program word decoder with status flags, host start/resume over APB and memory fetch.
// Assumes inputs synchronous to pclk and a memory that answers mem_req with mem_data_ready.
`timescale 1ns/1ps
`include "display_cfg.svh"

module display_instr_decode_status #(
	parameter int DEFL_WIDTH = 10,
	parameter int STEP_WIDTH = 6
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  clk_enable,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	output logic                       mem_req,
	output logic      [15:0]           mem_addr,
	input  wire logic                  mem_data_ready,
	input  wire logic [15:0]           mem_data,
	output logic                       stop_irq_request,
	input  wire logic                  stop_irq_ack,
	output logic                       host_start_strobe,
	output logic                       host_resume_strobe,
	input  wire logic                  line_rate_pulse,
	input  wire logic                  pen_detect_raw_n,
	output logic                       pen_hit_pulse,
	output logic      [3:0]            intensity_force_lines,
	input  wire logic [DEFL_WIDTH-1:0] x_drive_in,
	input  wire logic [DEFL_WIDTH-1:0] y_drive_in,
	output logic      [DEFL_WIDTH-1:0] x_drive_out,
	output logic      [DEFL_WIDTH-1:0] y_drive_out,
	output logic      [3:0]            mode_select,
	output logic                       graphic_mode_decoded,
	output logic                       load_status_a_decoded,
	output logic                       load_status_b_decoded,
	output logic                       jump_decoded,
	output logic                       noop_decoded,
	output logic      [STEP_WIDTH-1:0] graph_step_out,
	output logic      [STEP_WIDTH-1:0] plot_step_value,
	output logic                       halt_flag,
	output logic                       frame_sync_flag,
	output logic                       halt_irq_enable,
	output logic                       slant_font_flag,
	output logic                       pen_hit_enable
);

	localparam logic [3:0] STATE_LAST = 4'(`STATE_CYCLES - 1);
	localparam logic [6:0] PEN_LAST   = 7'(`PEN_PULSE_CYCLES - 1);

	display_pkg::seq_state_type state;
	display_pkg::seq_state_type next_state;

	logic [3:0]  state_count;
	logic        state_done;
	logic [15:0] fetch_word;
	logic [2:0]  control_mode;
	logic [2:0]  data_mode;
	logic        cont_word;
	logic        jump_word;
	logic [15:0] display_program_counter;
	logic        line_rate_prev;
	logic        pen_raw_prev;
	logic [6:0]  pen_timer;
	logic        spare_decoded;
	logic        apb_done;
	logic        apb_write;
	logic        write_control;
	logic        resume_request;
	logic        start_request;
	logic        load_mode_end;
	logic        load_pulse_end;
	logic        tp1_end;
	logic        tp2_end;
	logic        line_rate_fall;

	// Zero wait states; a frozen block holds the bus off instead of losing a write.
	assign pready         = clk_enable;
	assign apb_done       = psel && penable && clk_enable;
	assign apb_write      = apb_done && pwrite;
	assign write_control  = apb_write && (paddr == `REG_CONTROL_ADDR);
	// The completed access is the access-phase cycle with psel, penable and pready all high.
	assign resume_request = write_control && pwdata[`CTRL_RESUME_BIT] && (state == display_pkg::SEQ_WAIT)
		&& halt_flag;
	// A resume write suppresses the start action and so the counter load.
	assign start_request  = write_control && !pwdata[`CTRL_RESUME_BIT];

	assign state_done     = (state_count == STATE_LAST);
	assign load_mode_end  = (state == display_pkg::SEQ_LOAD_MODE) && state_done;
	assign load_pulse_end = (state == display_pkg::SEQ_LOAD_PULSE) && state_done;
	assign tp1_end        = (state == display_pkg::SEQ_TP1) && state_done;
	assign tp2_end        = (state == display_pkg::SEQ_TP2) && state_done;
	assign line_rate_fall = line_rate_prev && !line_rate_pulse;

	// Mode select follows the cont-word flag, which tracks bit 15 of the last instruction word.
	assign mode_select           = cont_word ? {1'b1, control_mode} : {1'b0, data_mode};
	assign graphic_mode_decoded  = (mode_select == `MODE_GRAPHIC);
	assign jump_decoded          = (mode_select == `MODE_JUMP);
	assign noop_decoded          = (mode_select == `MODE_NOOP);
	assign load_status_a_decoded = (mode_select == `MODE_STATUS_A);
	assign load_status_b_decoded = (mode_select == `MODE_STATUS_B);
	assign spare_decoded         = (mode_select == 4'h9) || (mode_select == 4'hA) || (mode_select == 4'hB)
		|| (mode_select == `MODE_DATA_SPARE);

	assign mem_req           = (state == display_pkg::SEQ_FETCH);
	assign mem_addr          = display_program_counter;
	assign stop_irq_request  = halt_flag && halt_irq_enable;

	// Sequencer: each timing state lasts one period of the 5 MHz display clock.
	always_comb begin
		next_state = state;
		case (state)
			display_pkg::SEQ_IDLE: begin
				next_state = display_pkg::SEQ_IDLE;
			end
			display_pkg::SEQ_FETCH: begin
				if (mem_data_ready) begin
					next_state = display_pkg::SEQ_LOAD_MODE;
				end
			end
			display_pkg::SEQ_LOAD_MODE: begin
				if (state_done) begin
					next_state = display_pkg::SEQ_LOAD_PULSE;
				end
			end
			display_pkg::SEQ_LOAD_PULSE: begin
				if (spare_decoded) begin
					next_state = display_pkg::SEQ_HUNG;
				end else if (state_done) begin
					next_state = display_pkg::SEQ_TP1;
				end
			end
			display_pkg::SEQ_TP1: begin
				if (state_done) begin
					next_state = display_pkg::SEQ_TP2;
				end
			end
			display_pkg::SEQ_TP2: begin
				if (state_done) begin
					// Halt or sync withholds the next fetch.
					if (halt_flag || frame_sync_flag) begin
						next_state = display_pkg::SEQ_WAIT;
					end else begin
						next_state = display_pkg::SEQ_FETCH;
					end
				end
			end
			display_pkg::SEQ_WAIT: begin
				if (resume_request) begin
					next_state = display_pkg::SEQ_FETCH;
				end else if (!halt_flag && frame_sync_flag && line_rate_pulse) begin
					next_state = display_pkg::SEQ_FETCH;
				end else if (!halt_flag && !frame_sync_flag) begin
					next_state = display_pkg::SEQ_FETCH;
				end
			end
			display_pkg::SEQ_HUNG: begin
				next_state = display_pkg::SEQ_HUNG;
			end
			default: begin
				next_state = display_pkg::SEQ_IDLE;
			end
		endcase
		// A start write restarts the program anywhere except from a hang.
		if (start_request && (state != display_pkg::SEQ_HUNG)) begin
			next_state = display_pkg::SEQ_FETCH;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state       <= display_pkg::SEQ_IDLE;
			state_count <= 4'h0;
		end else if (clk_enable) begin
			state <= next_state;
			if (next_state != state || state_done) begin
				state_count <= 4'h0;
			end else begin
				state_count <= state_count + 4'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fetch_word <= 16'h0000;
		end else if (clk_enable && mem_req && mem_data_ready) begin
			fetch_word <= mem_data;
		end
	end

	// Mode registers and cont-word flag change at the end of load mode, never for a jump address.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_mode <= 3'h0;
			data_mode    <= 3'h0;
			cont_word    <= 1'b0;
		end else if (clk_enable && load_mode_end && !jump_word) begin
			if (fetch_word[`WORD_INSTR_BIT]) begin
				cont_word <= 1'b1;
				if (fetch_word[`WORD_CONTROL_BIT]) begin
					control_mode <= fetch_word[`WORD_OP_HI:`WORD_OP_LO];
				end else begin
					control_mode <= 3'h0;
					data_mode    <= fetch_word[`WORD_OP_HI:`WORD_OP_LO];
				end
			end else begin
				cont_word <= 1'b0;
			end
		end
	end

	// The jump-word flag marks that the next word is the jump target.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			jump_word <= 1'b0;
		end else if (clk_enable) begin
			if (start_request) begin
				jump_word <= 1'b0;
			end else if (tp2_end) begin
				jump_word <= jump_decoded && !jump_word;
			end
		end
	end

	// Program counter: start load, jump load at load pulse, else advance by two at TP1.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			display_program_counter <= 16'h0000;
		end else if (clk_enable) begin
			if (start_request) begin
				display_program_counter <= {pwdata[15:1], 1'b0};
			end else if (load_pulse_end && jump_word) begin
				display_program_counter <= {fetch_word[15:1], 1'b0};
			end else if (tp1_end && !jump_word) begin
				display_program_counter <= display_program_counter + 16'h0002;
			end
		end
	end

	// Halt flag: set by status A, cleared when a resume or start write completes; set wins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_flag <= 1'b0;
		end else if (clk_enable) begin
			if (load_pulse_end && !jump_word && load_status_a_decoded && fetch_word[`STA_HALT_BIT]) begin
				halt_flag <= 1'b1;
			end else if (resume_request || start_request) begin
				halt_flag <= 1'b0;
			end
		end
	end

	// Sync flag: set by status A, cleared at the trailing edge of the line pulse; set wins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_sync_flag <= 1'b0;
			line_rate_prev  <= 1'b0;
		end else if (clk_enable) begin
			line_rate_prev <= line_rate_pulse;
			if (load_pulse_end && !jump_word && load_status_a_decoded && fetch_word[`STA_SYNC_BIT]) begin
				frame_sync_flag <= 1'b1;
			end else if (line_rate_fall) begin
				frame_sync_flag <= 1'b0;
			end
		end
	end

	// Writable status A flags; the acknowledge clears the enable unless status A sets it that cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_irq_enable <= 1'b0;
			slant_font_flag <= 1'b0;
			pen_hit_enable  <= 1'b0;
		end else if (clk_enable) begin
			if (load_pulse_end && !jump_word && load_status_a_decoded) begin
				halt_irq_enable <= fetch_word[`STA_IRQ_EN_BIT];
				slant_font_flag <= fetch_word[`STA_SLANT_BIT];
				pen_hit_enable  <= fetch_word[`STA_PEN_EN_BIT];
			end else if (stop_irq_ack) begin
				halt_irq_enable <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			plot_step_value <= '0;
		end else if (clk_enable && load_pulse_end && !jump_word && load_status_b_decoded
			&& fetch_word[`STB_LOAD_BIT]) begin
			plot_step_value <= fetch_word[STEP_WIDTH-1:0];
		end
	end

	// The step reaches the graph multiplexer only in graph X or graph Y mode.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			graph_step_out <= '0;
		end else if (clk_enable) begin
			if (mode_select == `MODE_GRAPH_X || mode_select == `MODE_GRAPH_Y) begin
				graph_step_out <= plot_step_value;
			end else begin
				graph_step_out <= '0;
			end
		end
	end

	// Slanting adds half of Y to X; the sum wraps, so callers keep headroom in X.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			x_drive_out <= '0;
			y_drive_out <= '0;
		end else if (clk_enable) begin
			y_drive_out <= y_drive_in;
			if (slant_font_flag) begin
				x_drive_out <= x_drive_in + {1'b0, y_drive_in[DEFL_WIDTH-1:1]};
			end else begin
				x_drive_out <= x_drive_in;
			end
		end
	end

	// Pen hit one-shot; a hit during the pulse does not retrigger it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pen_raw_prev          <= 1'b1;
			pen_timer             <= 7'h00;
			pen_hit_pulse         <= 1'b0;
			intensity_force_lines <= 4'h0;
		end else if (clk_enable) begin
			pen_raw_prev <= pen_detect_raw_n;
			if (!pen_hit_pulse && pen_raw_prev && !pen_detect_raw_n) begin
				pen_hit_pulse <= 1'b1;
				pen_timer     <= PEN_LAST;
			end else if (pen_hit_pulse) begin
				if (pen_timer == 7'h00) begin
					pen_hit_pulse <= 1'b0;
				end else begin
					pen_timer <= pen_timer - 7'h01;
				end
			end
			intensity_force_lines <= (pen_hit_pulse && !pen_hit_enable) ? 4'hF : 4'h0;
		end
	end

	// Host strobes are single-cycle pulses after the completed control write.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_start_strobe  <= 1'b0;
			host_resume_strobe <= 1'b0;
		end else if (clk_enable) begin
			host_start_strobe  <= start_request;
			host_resume_strobe <= resume_request;
		end
	end

	// APB read data and error for unmapped addresses.
	always_comb begin
		prdata  = 32'h0000_0000;
		pslverr = 1'b0;
		if (paddr == `REG_CONTROL_ADDR) begin
			prdata = 32'h0000_0000;
		end else if (paddr == `REG_STATUS_ADDR) begin
			prdata[`ST_HALT_BIT]   = halt_flag;
			prdata[`ST_SYNC_BIT]   = frame_sync_flag;
			prdata[`ST_IRQ_EN_BIT] = halt_irq_enable;
			prdata[`ST_SLANT_BIT]  = slant_font_flag;
			prdata[`ST_PEN_EN_BIT] = pen_hit_enable;
			prdata[`ST_HUNG_BIT]   = (state == display_pkg::SEQ_HUNG);
			prdata[`ST_RUN_BIT]    = (state != display_pkg::SEQ_IDLE);
			prdata[`ST_STEP_LO +: STEP_WIDTH] = plot_step_value;
		end else if (paddr == `REG_COUNTER_ADDR) begin
			prdata[15:0] = display_program_counter;
		end else begin
			pslverr = psel && penable;
		end
	end

endmodule

// file: sim/display_mem_model.sv
// Behavioural program memory on the far side of the fetch port.
// Assumes the bench preloads words and sets the answer delay in cycles.
`timescale 1ns/1ps
module display_mem_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [3:0]  delay,
	input  wire logic        mem_req,
	input  wire logic [15:0] mem_addr,
	output logic             mem_data_ready,
	output logic      [15:0] mem_data
);
	logic [15:0] words [0:127];
	logic [3:0]  waited;
	// Outside a reply the data lines toggle, so a late sample never looks valid.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_data_ready <= 1'h0;
			mem_data       <= 16'hA5A5;
			waited         <= 4'h0;
		end else if (mem_req && !mem_data_ready && waited >= delay) begin
			mem_data_ready <= 1'h1;
			mem_data       <= words[mem_addr[7:1]];
			waited         <= 4'h0;
		end else begin
			mem_data_ready <= 1'h0;
			mem_data       <= ~mem_data;
			waited         <= mem_req ? waited + 4'h1 : 4'h0;
		end
	end
endmodule

// file: sim/display_decode_properties.sv
// Port-level checks on the display decoder, bound into every instance.
// Assumes clk_enable stays high, so each timing state runs its full count.
`timescale 1ns/1ps
`include "display_cfg.svh"
module display_decode_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        mem_req,
	input wire logic [15:0] mem_addr,
	input wire logic        mem_data_ready,
	input wire logic        stop_irq_request,
	input wire logic        stop_irq_ack,
	input wire logic        host_resume_strobe,
	input wire logic        line_rate_pulse,
	input wire logic        pen_hit_pulse,
	input wire logic [3:0]  intensity_force_lines,
	input wire logic        load_status_a_decoded,
	input wire logic        halt_flag,
	input wire logic        frame_sync_flag,
	input wire logic        halt_irq_enable,
	input wire logic        pen_hit_enable
);
	logic [7:0] pen_len;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pen_len <= 8'h00;
		end else begin
			pen_len <= pen_hit_pulse ? pen_len + 8'h01 : 8'h00;
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_irq_needs_both: assert property (stop_irq_request == (halt_flag && halt_irq_enable))
		else $error("stop request wrong");
	a_halt_no_fetch: assert property ($rose(mem_req) |-> !halt_flag)
		else $error("fetch while halted");
	a_fetch_spacing: assert property (mem_req && mem_data_ready |=> (!mem_req) [*8] ##32 !mem_req)
		else $error("fetch too soon");
	a_resume_keeps_pc: assert property (
		host_resume_strobe |-> !halt_flag && mem_req && $stable(mem_addr))
		else $error("resume wrong");
	// While halted no load pulse can be under way, so an acknowledge then must always win.
	a_ack_clears_en: assert property (stop_irq_ack && (halt_flag || !load_status_a_decoded) |=> !halt_irq_enable)
		else $error("ack kept enable");
	a_sync_trailing: assert property ($fell(line_rate_pulse) |-> ##[1:3] !frame_sync_flag)
		else $error("sync not cleared");
	a_pen_width: assert property ($fell(pen_hit_pulse) |-> pen_len == `PEN_PULSE_CYCLES)
		else $error("pen pulse width wrong");
	a_pen_force: assert property (
		intensity_force_lines == ($past(pen_hit_pulse && !pen_hit_enable) ? 4'hF : 4'h0))
		else $error("intensity force wrong");
	c_resume: cover property (host_resume_strobe);
	c_irq: cover property ($rose(stop_irq_request));
	c_pen: cover property ($rose(pen_hit_pulse));
endmodule
bind display_instr_decode_status display_decode_checker u_checker (
	.pclk, .presetn, .mem_req, .mem_addr, .mem_data_ready, .stop_irq_request, .stop_irq_ack,
	.host_resume_strobe, .line_rate_pulse, .pen_hit_pulse, .intensity_force_lines,
	.load_status_a_decoded, .halt_flag, .frame_sync_flag, .halt_irq_enable, .pen_hit_enable
);

// file: sim/tb_top.sv
// Self-checking bench: APB host tasks, a program memory model and one task per scenario.
// Assumes the package, config header, memory model and bound checker are compiled first.
`timescale 1ns/1ps
`include "display_cfg.svh"
module tb_top;
	logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
	logic        stop_irq_ack = 1'h0, line_rate_pulse = 1'h0, pen_detect_raw_n = 1'h1, clk_en = 1'h1;
	logic        pready, pslverr, mem_req, mem_data_ready, stop_irq_request, host_start_strobe;
	logic        host_resume_strobe, pen_hit_pulse, graphic_mode_decoded, load_status_a_decoded;
	logic        load_status_b_decoded, jump_decoded, noop_decoded, halt_flag, frame_sync_flag;
	logic        halt_irq_enable, slant_font_flag, pen_hit_enable;
	logic [3:0]  delay = 4'h0, intensity_force_lines, mode_select;
	logic [5:0]  graph_step_out, plot_step_value;
	logic [9:0]  x_drive_in = 10'h000, y_drive_in = 10'h000, x_drive_out, y_drive_out;
	logic [11:0] paddr = 12'h000;
	logic [15:0] mem_addr, mem_data;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	int          n_errors = 0, comparisons = 0, cycles = 0;

	display_instr_decode_status u_dut (
		.pclk, .presetn, .clk_enable(clk_en), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .mem_req, .mem_addr, .mem_data_ready, .mem_data, .stop_irq_request,
		.stop_irq_ack, .host_start_strobe, .host_resume_strobe, .line_rate_pulse, .pen_detect_raw_n,
		.pen_hit_pulse, .intensity_force_lines, .x_drive_in, .y_drive_in, .x_drive_out, .y_drive_out,
		.mode_select, .graphic_mode_decoded, .load_status_a_decoded, .load_status_b_decoded,
		.jump_decoded, .noop_decoded, .graph_step_out, .plot_step_value, .halt_flag, .frame_sync_flag,
		.halt_irq_enable, .slant_font_flag, .pen_hit_enable
	);
	display_mem_model u_mem (.pclk, .presetn, .delay, .mem_req, .mem_addr, .mem_data_ready, .mem_data);

	always #10 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			stop_test();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'h1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic fetch();
		do @(posedge pclk); while (mem_req !== 1'h1 || mem_data_ready !== 1'h1);
	endtask
	task automatic pen(input logic [3:0] exp);
		pen_detect_raw_n <= 1'h0;
		@(posedge pclk);
		pen_detect_raw_n <= 1'h1;
		repeat (5) @(posedge pclk);
		check({pen_hit_pulse, intensity_force_lines}, {1'h1, exp});
		repeat (110) @(posedge pclk);
		check({pen_hit_pulse, intensity_force_lines}, 5'h00);
	endtask

	task automatic t_reset();
		apb(1'h0, `REG_STATUS_ADDR, 32'h00000000);
		check(rd, 32'h00000000);
		apb(1'h0, 12'h010, 32'h00000000);
		check({err, rd[30:0]}, 32'h80000000);
		$display("reset test done");
	endtask
	task automatic t_status();
		u_mem.words[0] = 16'hF150;
		u_mem.words[1] = 16'hF86A;
		u_mem.words[2] = 16'hF815;
		u_mem.words[3] = 16'hF550;
		apb(1'h1, `REG_CONTROL_ADDR, 32'h00000000);
		repeat (4) fetch();
		repeat (45) @(posedge pclk);
		check(mem_req, 1'h0);
		check(stop_irq_request, 1'h1);
		apb(1'h0, `REG_STATUS_ADDR, 32'h00000000);
		check(rd, 32'h00002A5D);
		apb(1'h0, `REG_COUNTER_ADDR, 32'h00000000);
		check(rd, 32'h00000008);
		x_drive_in <= 10'h100;
		y_drive_in <= 10'h0F0;
		repeat (3) @(posedge pclk);
		check({x_drive_out, y_drive_out}, {10'h178, 10'h0F0});
		clk_en     <= 1'h0;
		x_drive_in <= 10'h000;
		repeat (3) @(posedge pclk);
		check({pready, x_drive_out}, {1'h0, 10'h178});
		clk_en <= 1'h1;
		pen(4'h0);
		$display("status test done");
	endtask
	task automatic t_resume();
		logic [15:0] addrs [7] = '{16'h0008, 16'h000A, 16'h000C, 16'h000E, 16'h0010, 16'h8040, 16'h8042};
		logic [3:0]  modes [7] = '{4'hD, 4'h8, 4'h4, 4'hC, 4'hC, 4'h4, 4'hE};
		logic [4:0]  decs [7]  = '{5'h01, 5'h10, 5'h00, 5'h02, 5'h02, 5'h00, 5'h08};
		stop_irq_ack <= 1'h1;
		@(posedge pclk);
		stop_irq_ack <= 1'h0;
		@(posedge pclk);
		check({stop_irq_request, halt_irq_enable}, 2'h0);
		u_mem.words[4] = 16'hE800;
		u_mem.words[5] = 16'hA000;
		u_mem.words[6] = 16'h0123;
		u_mem.words[7] = 16'hE000;
		u_mem.words[8] = 16'h8040;
		u_mem.words[32] = 16'h0055;
		u_mem.words[33] = 16'hF400;
		delay <= 4'h3;
		apb(1'h1, `REG_CONTROL_ADDR, 32'h00000001);
		@(posedge pclk);
		check({host_resume_strobe, host_start_strobe}, 2'h2);
		for (int i = 0; i < 7; i++) begin
			fetch();
			check(mem_addr, addrs[i]);
			repeat (15) @(posedge pclk);
			check(mode_select, modes[i]);
			check({graphic_mode_decoded, load_status_a_decoded, load_status_b_decoded, jump_decoded,
				noop_decoded}, decs[i]);
			if (i == 2) check(graph_step_out, 6'h2A);
		end
		repeat (45) @(posedge pclk);
		check(stop_irq_request, 1'h0);
		apb(1'h0, `REG_STATUS_ADDR, 32'h00000000);
		check(rd, 32'h00002A41);
		apb(1'h0, `REG_COUNTER_ADDR, 32'h00000000);
		check(rd, 32'h00008044);
		pen(4'hF);
		$display("resume test done");
	endtask
	task automatic t_sync();
		u_mem.words[48] = 16'hF004;
		u_mem.words[49] = 16'hE800;
		u_mem.words[50] = 16'hF400;
		delay <= 4'h0;
		apb(1'h1, `REG_CONTROL_ADDR, 32'h00000060);
		@(posedge pclk);
		check(host_start_strobe, 1'h1);
		fetch();
		repeat (100) @(posedge pclk);
		check({frame_sync_flag, mem_req}, 2'h2);
		line_rate_pulse <= 1'h1;
		fetch();
		line_rate_pulse <= 1'h0;
		check(mem_addr, 16'h0062);
		repeat (4) @(posedge pclk);
		check(frame_sync_flag, 1'h0);
		fetch();
		repeat (45) @(posedge pclk);
		$display("sync test done");
	endtask
	task automatic t_hang();
		u_mem.words[64] = 16'hC800;
		apb(1'h1, `REG_CONTROL_ADDR, 32'h00000080);
		fetch();
		repeat (60) @(posedge pclk);
		apb(1'h1, `REG_CONTROL_ADDR, 32'h00000080);
		repeat (60) @(posedge pclk);
		check(mem_req, 1'h0);
		apb(1'h0, `REG_STATUS_ADDR, 32'h00000000);
		check(rd[5], 1'h1);
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, `REG_STATUS_ADDR, 32'h00000000);
		check(rd, 32'h00000000);
		$display("hang test done");
	endtask
	task automatic stop_test();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		t_reset();
		t_status();
		t_resume();
		t_sync();
		t_hang();
		stop_test();
	end
endmodule
